// [src/bbio_pkg.sv]
// package: constants and types for the buffered block transfer engine
package bbio_pkg;
    localparam int BBIO_DW       = 24;
    localparam int BBIO_FW       = 17;
    localparam int BBIO_AW       = BBIO_FW + 2;
    localparam int BBIO_CHANNELS = 8;
    localparam int BBIO_BUS_AW   = 8;

    localparam logic [7:0] BBIO_OFF_WORD0  = 8'h00;
    localparam logic [7:0] BBIO_OFF_WORD1  = 8'h04;
    localparam logic [7:0] BBIO_OFF_STATUS = 8'h08;
    localparam logic [1:0] BBIO_OFF_SLOTS  = 2'h1;
    localparam logic [3:0] BBIO_SLOT_LIMIT = 4'h8;

    localparam logic [5:0] BBIO_OP_CHAR_IN  = 6'h3B;
    localparam logic [5:0] BBIO_OP_WORD_IN  = 6'h3C;
    localparam logic [5:0] BBIO_OP_CHAR_OUT = 6'h3D;

    localparam int BBIO_W0_OP_LSB    = 18;
    localparam int BBIO_W0_WIDE_BIT  = 17;
    localparam int BBIO_W1_CH_LSB    = 21;
    localparam int BBIO_W1_CONT_BIT  = 20;
    localparam int BBIO_W1_DIR_BIT   = 19;
    localparam int BBIO_W1_ASM_BIT   = 18;
    localparam int BBIO_W1_INT_BIT   = 17;
    localparam int BBIO_ST_IRQ_BIT   = 8;
    localparam int BBIO_ST_SKIP_BIT  = 9;
    localparam int BBIO_ST_DONE_BIT  = 10;

    localparam logic [1:0] BBIO_RESUME_RUN  = 2'h3;
    localparam logic [1:0] BBIO_RESUME_BUSY = 2'h2;

    localparam int BBIO_CLK_MHZ        = 40;
    localparam int BBIO_REREAD_GAP_NS  = 200;
    localparam int BBIO_REREAD_GAP_CYC =
        (BBIO_REREAD_GAP_NS * BBIO_CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        BBIO_ELEM_CHAR,
        BBIO_ELEM_HALF,
        BBIO_ELEM_WORD
    } bbio_elem_type;

    typedef struct packed {
        logic          to_mem;
        bbio_elem_type elem;
        logic          dir;
        logic          cont;
        logic          irq_en;
        logic          wide;
        logic [2:0]    chan;
    } bbio_cmd_type;

    typedef struct packed {
        logic [BBIO_DW-1:0] data;
        logic [3:0]         mask;
    } bbio_lane_type;
endpackage : bbio_pkg

// [src/bbio_lane.sv]
// character and half-word lane placement and extraction
module bbio_lane
    import bbio_pkg::*;
(
    input  bbio_elem_type             elem,
    input  wire logic                 wide,
    input  wire logic [1:0]           pos,
    input  wire logic [BBIO_DW-1:0]   in_data,
    input  wire logic [BBIO_DW-1:0]   rd_word,
    output bbio_lane_type             lane,
    output logic [BBIO_DW-1:0]        out_data
);
    // char 0 is the top six bits
    always_comb begin
        lane.data = in_data;
        lane.mask = 4'hF;
        out_data  = rd_word;
        unique case (elem)
            BBIO_ELEM_CHAR: begin
                lane.data = {4{in_data[5:0]}};
                lane.mask = 4'h8 >> pos;
                unique case (pos)
                    2'h0: out_data = {18'h00000, rd_word[23:18]};
                    2'h1: out_data = {18'h00000, rd_word[17:12]};
                    2'h2: out_data = {18'h00000, rd_word[11:6]};
                    2'h3: out_data = {18'h00000, rd_word[5:0]};
                endcase
            end
            BBIO_ELEM_HALF: begin
                lane.data = {2{in_data[11:0]}};
                lane.mask = pos[1] ? 4'h3 : 4'hC;
                out_data  = pos[1] ? {12'h000, rd_word[11:0]}
                                   : {12'h000, rd_word[23:12]};
            end
            BBIO_ELEM_WORD: begin
                // narrow channel leaves the upper half
                if (!wide) begin
                    lane.data = {12'h000, in_data[11:0]};
                    lane.mask = 4'h3;
                end
            end
            default: begin
                lane.mask = 4'h0;
            end
        endcase
    end
endmodule : bbio_lane

// [src/bbio_engine.sv]
// buffered block transfer engine between core storage and a data channel
// How it works
// - char input, field 0: low 6 bits per char
// - char mode steps +1 forward, -1 backward
// - char input, field 1: bytes into halves, step 2
// - half assembly forces address bit 0 low
// - idle with a valid op starts, resume P+3; busy or invalid op skips, resume P+2
// - continue bit runs input past end of record
// - continue: read drops at end of record, then returns
// - word input moves bytes or words by channel width
// - word assembly starts upper forward, lower backward
// - no assembly: narrow keeps upper 12 bits, wide writes all
// - char output, field 0: 6-bit chars, step 1
// - char output, field 1: half words, step 2
// - first address advances live; block ends at limit
// - interrupt bit raises interrupt at block end
// - assembly field decode differs by input kind
// - current address in slot chan, limit in 8 plus chan
// - word addresses shift left two into char addresses
//
// Implementation choices: the register offsets and the strobed register port.
module bbio_engine
    import bbio_pkg::*;
#(
    parameter int REREAD_GAP_CYC = BBIO_REREAD_GAP_CYC
)(
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST,
    input  wire logic [BBIO_BUS_AW-1:0] ADDR,
    input  wire logic [BBIO_DW-1:0]    WR_DATA,
    input  wire logic                  WR_STROBE,
    input  wire logic                  RD_STROBE,
    output logic [BBIO_DW-1:0]         RD_DATA,
    output logic                       NEXT_INSTRUCTION_FETCH,
    output logic [1:0]                 NEXT_FETCH_OFFSET,
    output logic                       IRQ,
    output logic [BBIO_FW-1:0]         MEM_ADDR,
    output logic [BBIO_DW-1:0]         MEM_WDATA,
    output logic [3:0]                 MEM_WMASK,
    output logic                       MEM_WE,
    output logic                       MEM_RE,
    input  wire logic [BBIO_DW-1:0]    MEM_RDATA,
    input  wire logic [BBIO_DW-1:0]    CH_DATA_IN,
    input  wire logic                  CH_IN_TOGGLE,
    input  wire logic                  CH_EOR_TOGGLE,
    input  wire logic                  CH_OUT_ACK_TOGGLE,
    output logic                       CH_READ,
    output logic                       CH_WRITE,
    output logic                       CH_IN_ACK_TOGGLE,
    output logic                       CH_OUT_TOGGLE,
    output logic [BBIO_DW-1:0]         CH_DATA_OUT
);
    if (REREAD_GAP_CYC < 1 || REREAD_GAP_CYC > 255) begin : g_chk
        $error("REREAD_GAP_CYC must lie in 1..255");
    end

    typedef enum {
        S_IDLE, S_WAIT_IN, S_STORE, S_GAP, S_FETCH, S_LATCH, S_SEND, S_FINISH
    } bbio_state_type;

    function automatic logic [2:0] span_of(input bbio_elem_type e);
        unique case (e)
            BBIO_ELEM_HALF: return 3'h2;
            BBIO_ELEM_WORD: return 3'h4;
            default:        return 3'h1;
        endcase
    endfunction : span_of

    // element at a overruns the block end lim
    function automatic logic elem_done(input logic [BBIO_AW-1:0] a,
                                       input logic [BBIO_AW-1:0] lim,
                                       input bbio_elem_type e,
                                       input logic back);
        if (back) begin
            return a <= lim;
        end
        return ({1'b0, a} + {{(BBIO_AW-2){1'b0}}, span_of(e)})
               > {1'b0, lim};
    endfunction : elem_done

    bbio_state_type       state;
    bbio_state_type       next_state;
    bbio_cmd_type         cmd;
    bbio_cmd_type         l_cmd;
    bbio_lane_type        lane;
    logic [BBIO_DW-1:0]   word0;
    logic [BBIO_DW-1:0]   slot [2*BBIO_CHANNELS];
    logic [BBIO_AW-1:0]   cur;
    logic [BBIO_AW-1:0]   lim;
    logic [BBIO_AW-1:0]   next_cur;
    logic [BBIO_AW-1:0]   stepped;
    logic [BBIO_AW-1:0]   l_first;
    logic [BBIO_AW-1:0]   l_limit;
    logic [BBIO_DW-1:0]   data_meta;
    logic [BBIO_DW-1:0]   data_sync;
    logic [BBIO_DW-1:0]   out_data;
    logic [BBIO_DW-1:0]   next_rd_data;
    logic [2:0]           tog_meta;
    logic [2:0]           tog_sync;
    logic [2:0]           tog_prev;
    logic [2:0]           evt;
    logic [7:0]           gap_cnt;
    logic [5:0]           l_op;
    logic                 launch;
    logic                 l_op_ok;
    logic                 accept;
    logic                 start_empty;
    logic                 step_now;
    logic                 step_done;
    logic                 irq_flag;
    logic                 done_flag;
    logic                 skip_flag;
    logic                 clr_flags;

    // asynchronous equipment pins: two stages before use
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            data_meta <= '0;
            data_sync <= '0;
            tog_meta  <= '0;
            tog_sync  <= '0;
            tog_prev  <= '0;
        end else begin
            data_meta <= CH_DATA_IN;
            data_sync <= data_meta;
            tog_meta  <= {CH_OUT_ACK_TOGGLE, CH_EOR_TOGGLE, CH_IN_TOGGLE};
            tog_sync  <= tog_meta;
            tog_prev  <= tog_sync;
        end
    end
    assign evt = tog_sync ^ tog_prev;

    // writing the second word launches
    assign launch  = WR_STROBE && (ADDR == BBIO_OFF_WORD1);
    assign l_op    = word0[BBIO_W0_OP_LSB +: 6];
    assign l_op_ok = (l_op == BBIO_OP_CHAR_IN) || (l_op == BBIO_OP_WORD_IN)
                     || (l_op == BBIO_OP_CHAR_OUT);

    always_comb begin
        l_cmd.to_mem = (l_op != BBIO_OP_CHAR_OUT);
        l_cmd.dir    = WR_DATA[BBIO_W1_DIR_BIT];
        l_cmd.cont   = WR_DATA[BBIO_W1_CONT_BIT] && l_cmd.to_mem;
        l_cmd.irq_en = WR_DATA[BBIO_W1_INT_BIT];
        l_cmd.wide   = word0[BBIO_W0_WIDE_BIT];
        l_cmd.chan   = WR_DATA[BBIO_W1_CH_LSB +: 3];
        if (l_op == BBIO_OP_WORD_IN) begin
            l_cmd.elem = WR_DATA[BBIO_W1_ASM_BIT] ? BBIO_ELEM_WORD
                                                  : BBIO_ELEM_HALF;
        end else begin
            l_cmd.elem = WR_DATA[BBIO_W1_ASM_BIT] ? BBIO_ELEM_HALF
                                                  : BBIO_ELEM_CHAR;
        end
        l_first = {2'b00, WR_DATA[BBIO_FW-1:0]};
        l_limit = {2'b00, word0[BBIO_FW-1:0]};
        if (l_op == BBIO_OP_WORD_IN) begin
            // backward half assembly begins in the lower half
            l_first = {WR_DATA[BBIO_FW-1:0],
                       (l_cmd.elem == BBIO_ELEM_HALF) && l_cmd.dir, 1'b0};
            l_limit = {word0[BBIO_FW-1:0],
                       (l_cmd.elem == BBIO_ELEM_HALF) && l_cmd.dir, 1'b0};
        end
        if (l_cmd.elem == BBIO_ELEM_HALF) begin
            l_first[0] = 1'b0;
        end
    end

    // single engine: any running block means busy
    assign accept = launch && l_op_ok && (state == S_IDLE);
    assign start_empty = elem_done(l_first, l_limit, l_cmd.elem, l_cmd.dir);

    assign stepped = cmd.dir
        ? cur - BBIO_AW'(span_of(cmd.elem))
        : cur + BBIO_AW'(span_of(cmd.elem));
    assign step_done = elem_done(stepped, lim, cmd.elem, cmd.dir);
    assign step_now  = (state == S_STORE) || (state == S_SEND && evt[2]);

    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE: begin
                if (accept) begin
                    next_state = start_empty ? S_FINISH
                               : (l_cmd.to_mem ? S_WAIT_IN : S_FETCH);
                end
            end
            S_WAIT_IN: begin
                if (evt[0]) begin
                    next_state = S_STORE;
                end else if (evt[1]) begin
                    next_state = cmd.cont ? S_GAP : S_FINISH;
                end
            end
            S_STORE:  next_state = step_done ? S_FINISH : S_WAIT_IN;
            S_GAP: begin
                if (gap_cnt == 8'h00) begin
                    next_state = S_WAIT_IN;
                end
            end
            S_FETCH:  next_state = S_LATCH;
            S_LATCH:  next_state = S_SEND;
            S_SEND: begin
                if (evt[2]) begin
                    next_state = step_done ? S_FINISH : S_FETCH;
                end
            end
            S_FINISH: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cmd <= '0;
            lim <= '0;
        end else if (accept) begin
            cmd <= l_cmd;
            lim <= l_limit;
        end
    end

    always_comb begin
        next_cur = cur;
        if (accept) begin
            next_cur = l_first;
        end else if (step_now) begin
            next_cur = stepped;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // slots mirror live current and limit addresses
    always_ff @(posedge CLK_SYS) begin
        if (accept) begin
            slot[{1'b0, l_cmd.chan}] <= BBIO_DW'(l_first);
            slot[BBIO_SLOT_LIMIT | {1'b0, l_cmd.chan}] <= BBIO_DW'(l_limit);
        end else if (step_now) begin
            slot[{1'b0, cmd.chan}] <= BBIO_DW'(stepped);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            gap_cnt <= '0;
        end else if (state == S_WAIT_IN) begin
            gap_cnt <= 8'(REREAD_GAP_CYC - 1);
        end else if (state == S_GAP) begin
            gap_cnt <= gap_cnt - 8'h01;
        end
    end

    bbio_lane u_lane (
        .elem     (cmd.elem),
        .wide     (cmd.wide),
        .pos      (cur[1:0]),
        .in_data  (data_sync),
        .rd_word  (MEM_RDATA),
        .lane     (lane),
        .out_data (out_data)
    );

    // storage address follows the live current address
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            MEM_ADDR  <= '0;
            MEM_WDATA <= '0;
            MEM_WMASK <= '0;
            MEM_WE    <= 1'b0;
            MEM_RE    <= 1'b0;
        end else begin
            MEM_ADDR <= next_cur[BBIO_AW-1:2];
            MEM_WE   <= (next_state == S_STORE);
            MEM_RE   <= (next_state == S_FETCH);
            if (next_state == S_STORE) begin
                MEM_WDATA <= lane.data;
                MEM_WMASK <= lane.mask;
            end
        end
    end

    // read line drops in the gap, then returns
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CH_READ          <= 1'b0;
            CH_WRITE         <= 1'b0;
            CH_IN_ACK_TOGGLE <= 1'b0;
            CH_OUT_TOGGLE    <= 1'b0;
            CH_DATA_OUT      <= '0;
        end else begin
            CH_READ  <= (next_state == S_WAIT_IN)
                        || (next_state == S_STORE);
            CH_WRITE <= (next_state == S_FETCH) || (next_state == S_LATCH)
                        || (next_state == S_SEND);
            if (state == S_STORE) begin
                CH_IN_ACK_TOGGLE <= ~CH_IN_ACK_TOGGLE;
            end
            if (state == S_LATCH) begin
                CH_DATA_OUT   <= out_data;
                CH_OUT_TOGGLE <= ~CH_OUT_TOGGLE;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            NEXT_INSTRUCTION_FETCH <= 1'b0;
            NEXT_FETCH_OFFSET      <= BBIO_RESUME_BUSY;
            skip_flag              <= 1'b0;
        end else begin
            NEXT_INSTRUCTION_FETCH <= launch;
            if (launch) begin
                NEXT_FETCH_OFFSET <= accept ? BBIO_RESUME_RUN
                                            : BBIO_RESUME_BUSY;
                skip_flag         <= !accept;
            end
        end
    end

    // completion beats a clear in the same cycle
    assign clr_flags = WR_STROBE && (ADDR == BBIO_OFF_STATUS)
                       && WR_DATA[BBIO_ST_IRQ_BIT];
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_flag  <= 1'b0;
            done_flag <= 1'b0;
        end else if (state == S_FINISH) begin
            irq_flag  <= cmd.irq_en || (irq_flag && !clr_flags);
            done_flag <= 1'b1;
        end else if (clr_flags) begin
            irq_flag  <= 1'b0;
            done_flag <= 1'b0;
        end
    end
    assign IRQ = irq_flag;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            word0 <= '0;
        end else if (WR_STROBE && ADDR == BBIO_OFF_WORD0) begin
            word0 <= WR_DATA;
        end
    end

    always_comb begin
        next_rd_data = '0;
        if (ADDR == BBIO_OFF_WORD0) begin
            next_rd_data = word0;
        end else if (ADDR == BBIO_OFF_STATUS) begin
            next_rd_data[BBIO_CHANNELS-1:0] = (state == S_IDLE) ? 8'h00
                : 8'(8'h01 << cmd.chan);
            next_rd_data[BBIO_ST_IRQ_BIT]  = irq_flag;
            next_rd_data[BBIO_ST_SKIP_BIT] = skip_flag;
            next_rd_data[BBIO_ST_DONE_BIT] = done_flag;
        end else if (ADDR[7:6] == BBIO_OFF_SLOTS) begin
            next_rd_data = slot[ADDR[5:2]];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RD_DATA <= '0;
        end else if (RD_STROBE) begin
            RD_DATA <= next_rd_data;
        end
    end
endmodule : bbio_engine

// [test/bbio_checker.sv]
// port assertions for the block transfer engine
module bbio_checker
    import bbio_pkg::*;
#(
    parameter int REREAD_GAP_CYC = BBIO_REREAD_GAP_CYC
)(
    input wire logic                   CLK_SYS,
    input wire logic                   RST,
    input wire logic [BBIO_BUS_AW-1:0] ADDR,
    input wire logic                   WR_STROBE,
    input wire logic                   RD_STROBE,
    input wire logic [BBIO_DW-1:0]     RD_DATA,
    input wire logic                   NEXT_INSTRUCTION_FETCH,
    input wire logic [1:0]             NEXT_FETCH_OFFSET,
    input wire logic                   IRQ,
    input wire logic [3:0]             MEM_WMASK,
    input wire logic                   MEM_WE,
    input wire logic                   MEM_RE,
    input wire logic                   CH_READ,
    input wire logic                   CH_WRITE,
    input wire logic                   CH_IN_ACK_TOGGLE,
    input wire logic                   CH_OUT_TOGGLE,
    input wire logic [BBIO_DW-1:0]     CH_DATA_OUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    wire launch = WR_STROBE && ADDR == BBIO_OFF_WORD1;
    int low_run = 0;
    always_ff @(posedge CLK_SYS) low_run <= CH_READ ? 0 : low_run + 1;
    // read line high: engine owned
    chk_fetch_pulse: assert property (launch |=>
        NEXT_INSTRUCTION_FETCH) else $error("no fetch pulse");
    chk_busy_skip: assert property (launch && CH_READ |=>
        NEXT_FETCH_OFFSET == BBIO_RESUME_BUSY) else $error("busy launch ran");
    chk_store_lanes: assert property (MEM_WE |-> MEM_WMASK inside
        {4'h8, 4'h4, 4'h2, 4'h1, 4'hC, 4'h3, 4'hF}) else $error("bad store lanes");
    chk_store_ack: assert property (MEM_WE |=> $changed(CH_IN_ACK_TOGGLE))
        else $error("no input ack");
    chk_out_flip: assert property (MEM_RE |-> ##2 $changed(CH_OUT_TOGGLE))
        else $error("no output toggle");
    chk_out_width: assert property ($changed(CH_OUT_TOGGLE) |->
        CH_DATA_OUT[23:12] == 12'h000) else $error("output upper bits set");
    chk_dir_excl: assert property (!(CH_READ && CH_WRITE))
        else $error("read and write");
    chk_irq_idle: assert property ($rose(IRQ) |-> !CH_READ && !MEM_RE)
        else $error("early interrupt");
    chk_reread_gap: assert property ($rose(CH_READ) |->
        low_run >= REREAD_GAP_CYC) else $error("read line back too soon");
    chk_unmapped_rd: assert property (RD_STROBE && ADDR == 8'hF0 |=>
        RD_DATA == 24'h000000) else $error("unmapped read not zero");
    cover property (launch ##1 NEXT_FETCH_OFFSET == BBIO_RESUME_BUSY);
    cover property ($rose(IRQ));
    cover property ($rose(CH_READ) && low_run == REREAD_GAP_CYC);
endmodule : bbio_checker

bind bbio_engine bbio_checker #(.REREAD_GAP_CYC(REREAD_GAP_CYC)) u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WR_STROBE(WR_STROBE),
    .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA), .IRQ(IRQ),
    .NEXT_INSTRUCTION_FETCH(NEXT_INSTRUCTION_FETCH),
    .NEXT_FETCH_OFFSET(NEXT_FETCH_OFFSET), .MEM_WMASK(MEM_WMASK),
    .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .CH_READ(CH_READ), .CH_WRITE(CH_WRITE),
    .CH_IN_ACK_TOGGLE(CH_IN_ACK_TOGGLE), .CH_OUT_TOGGLE(CH_OUT_TOGGLE),
    .CH_DATA_OUT(CH_DATA_OUT));

// [test/bbio_equipment.sv]
// equipment controller model on the far side of the data channel
module bbio_equipment
    import bbio_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               ch_read,
    input  wire logic               ch_in_ack,
    input  wire logic               ch_out_tog,
    input  wire logic [BBIO_DW-1:0] ch_data_out,
    output logic [BBIO_DW-1:0]      data_in,
    output logic                    in_tog,
    output logic                    eor_tog,
    output logic                    out_ack
);
    logic [BBIO_DW-1:0] in_q[$];
    logic [BBIO_DW-1:0] out_q[$];
    int                 sent, eor_after, slow, hold, pend;
    logic               busy, ack_ref, out_ref;
    initial begin
        {data_in, in_tog, eor_tog, out_ack, busy, ack_ref, out_ref} = '0;
        {sent, eor_after, slow, hold, pend} = '0;
    end
    always @(posedge clk) begin
        if (hold > 0) begin
            hold <= hold - 1;
        end else if (!busy && ch_read && in_q.size() > 0) begin
            data_in <= in_q.pop_front();
            in_tog  <= ~in_tog; // a returning read is a fresh request
            ack_ref <= ch_in_ack;
            busy    <= 1'b1;
        end else if (busy && ch_in_ack != ack_ref) begin
            data_in <= ~data_in; // released line shows inverse
            busy    <= 1'b0;
            sent    <= sent + 1;
            if (sent + 1 == eor_after) begin
                eor_tog <= ~eor_tog; // end of record
                hold    <= 12;
            end else begin
                hold <= slow ? $urandom % 4 : 0;
            end
        end
    end
    always @(posedge clk) begin
        if (ch_out_tog != out_ref) begin
            out_ref <= ch_out_tog;
            out_q.push_back(ch_data_out);
            pend    <= 1 + (slow ? $urandom % 5 : 0);
        end else if (pend == 1) begin
            out_ack <= ~out_ack;
            pend    <= 0;
        end else if (pend > 1) begin
            pend <= pend - 1;
        end
    end
endmodule : bbio_equipment

// [test/test_bbio_engine.sv]
// self-checking bench for the block transfer engine
module test_bbio_engine
    import bbio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   CLK_SYS = 1'b0, RST = 1'b1;
    logic [BBIO_BUS_AW-1:0] ADDR = '0;
    logic [BBIO_DW-1:0]     WR_DATA = '0, MEM_RDATA = '0, rv;
    logic                   WR_STROBE = 1'b0, RD_STROBE = 1'b0;
    logic [BBIO_DW-1:0]     RD_DATA, MEM_WDATA, CH_DATA_IN, CH_DATA_OUT;
    logic [1:0]             NFO;
    logic [BBIO_FW-1:0]     MEM_ADDR;
    logic [3:0]             MEM_WMASK;
    logic NIF, IRQ, MEM_WE, MEM_RE, IN_T, EOR_T, OACK_T, CH_READ, CH_WRITE;
    logic IACK_T, OUT_T;
    logic [BBIO_DW-1:0]     mem [64];
    int                     exp_mem [64];
    int                     exp_out[$];
    int                     err_count, compares;
    bbio_engine #(.REREAD_GAP_CYC(2)) DUT (
        .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA),
        .NEXT_INSTRUCTION_FETCH(NIF), .NEXT_FETCH_OFFSET(NFO), .IRQ(IRQ),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_WMASK(MEM_WMASK),
        .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_RDATA(MEM_RDATA),
        .CH_DATA_IN(CH_DATA_IN), .CH_IN_TOGGLE(IN_T), .CH_EOR_TOGGLE(EOR_T),
        .CH_OUT_ACK_TOGGLE(OACK_T), .CH_READ(CH_READ), .CH_WRITE(CH_WRITE),
        .CH_IN_ACK_TOGGLE(IACK_T), .CH_OUT_TOGGLE(OUT_T),
        .CH_DATA_OUT(CH_DATA_OUT));
    bbio_equipment EQ (
        .clk(CLK_SYS), .ch_read(CH_READ), .ch_in_ack(IACK_T),
        .ch_out_tog(OUT_T), .ch_data_out(CH_DATA_OUT), .data_in(CH_DATA_IN),
        .in_tog(IN_T), .eor_tog(EOR_T), .out_ack(OACK_T));
    initial forever #12.5 CLK_SYS = ~CLK_SYS;
    // core storage, data a cycle after the read
    always @(posedge CLK_SYS) begin
        if (MEM_RE) MEM_RDATA <= mem[MEM_ADDR[5:0]];
        for (int k = 0; k < 4; k++)
            if (MEM_WE && MEM_WMASK[k]) mem[MEM_ADDR[5:0]][k*6 +: 6] <= MEM_WDATA[k*6 +: 6];
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [23:0] d);
        @(posedge CLK_SYS);
        ADDR      <= a;
        WR_DATA   <= d;
        WR_STROBE <= 1'b1;
        @(posedge CLK_SYS);
        WR_STROBE <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [23:0] d);
        @(posedge CLK_SYS);
        ADDR      <= a;
        RD_STROBE <= 1'b1;
        @(posedge CLK_SYS);
        RD_STROBE <= 1'b0;
        #1 d = RD_DATA;
    endtask : rd
    task automatic conclude();
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // one block: expect, launch, wait, compare
    task automatic go(logic [5:0] op, logic wd, dir, asm, cont, irq,
                      int first, lim, eor_at, slow);
        int a, l, sp, n, sh, m;
        logic [23:0] d, w1;
        logic [2:0]  ch;
        ch = 3'($urandom);
        l  = lim;
        a  = first;
        sp = asm ? 2 : 1;
        if (op == BBIO_OP_WORD_IN) begin
            l  = (lim << 2) + (!asm && dir ? 2 : 0);
            a  = (first << 2) + (!asm && dir ? 2 : 0);
            sp = asm ? 4 : 2;
        end else if (asm) a = first & ~1;
        EQ.sent = 0;
        EQ.eor_after = eor_at;
        EQ.slow = slow;
        EQ.out_q.delete();
        exp_out.delete();
        n = 0;
        // odd half counts drop the tail
        while ((dir ? a > l : a + sp <= l) && (cont || eor_at == 0 || n < eor_at)) begin
            d  = 24'($urandom) & (wd ? 24'hFFFFFF : 24'h000FFF);
            sh = sp == 1 ? (3 - a % 4) * 6 : (sp == 2 && a % 4 == 0 ? 12 : 0);
            m  = sp == 1 ? 'h3F : (sp == 4 && wd ? 'hFFFFFF : 'hFFF);
            if (op == BBIO_OP_CHAR_OUT) exp_out.push_back((exp_mem[a/4] >> sh) & m);
            else exp_mem[a/4] = (exp_mem[a/4] & ~(m << sh)) | ((d & m) << sh);
            if (op != BBIO_OP_CHAR_OUT) EQ.in_q.push_back(d);
            a = dir ? a - sp : a + sp;
            n++;
        end
        w1 = {ch, cont, dir, asm, irq, 17'(first)}; // cont at bit 20, first in bits 16..0
        wr(BBIO_OFF_WORD0, {op, wd, 17'(lim)});
        wr(BBIO_OFF_WORD1, w1);
        #1 chk("fetch", 1, NIF);
        chk("resume", BBIO_RESUME_RUN, NFO);
        if (slow) wr(BBIO_OFF_WORD1, w1);
        if (slow) #1 chk("skip", BBIO_RESUME_BUSY, NFO);
        for (int t = 0; t < 3000; t++) begin
            rd(BBIO_OFF_STATUS, rv);
            if (rv[BBIO_ST_DONE_BIT] === 1'b1) break;
        end
        if (rv[BBIO_ST_DONE_BIT] !== 1'b1) begin
            err_count++;
            conclude();
        end
        chk("irq", irq, IRQ);
        rd(8'h40 + 4 * ch, rv);
        chk("current", a, rv);
        rd(8'h60 + 4 * ch, rv);
        chk("limit", l, rv);
        chk("unread", 0, EQ.in_q.size());
        for (int i = 0; i < 64; i++) chk("mem", exp_mem[i], mem[i]);
        chk("out count", exp_out.size(), EQ.out_q.size());
        for (int i = 0; i < exp_out.size(); i++) chk("out", exp_out[i], EQ.out_q[i]);
        wr(BBIO_OFF_STATUS, 24'h000100);
        #1 chk("irq clear", 0, IRQ);
    endtask : go
    initial begin
        void'($urandom(98189));
        for (int i = 0; i < 64; i++) begin
            mem[i]     = 24'($urandom);
            exp_mem[i] = mem[i];
        end
        repeat (2) @(posedge CLK_SYS);
        RST <= 1'b0;
        rd(8'hF0, rv);
        chk("unmapped", 0, rv);
        rd(BBIO_OFF_WORD1, rv);
        chk("word1 read", 0, rv);
        go(BBIO_OP_CHAR_IN, 0, 0, 0, 0, 1, 5, 15, 0, 1);
        go(BBIO_OP_CHAR_IN, 1, 1, 0, 1, 0, 60, 48, 3, 0);
        go(BBIO_OP_CHAR_IN, 0, 0, 1, 0, 1, 81, 89, 0, 0);
        go(BBIO_OP_CHAR_IN, 0, 1, 1, 0, 0, 100, 90, 0, 1);
        go(BBIO_OP_WORD_IN, 0, 0, 0, 0, 1, 30, 33, 0, 0);
        go(BBIO_OP_WORD_IN, 0, 1, 0, 0, 0, 40, 37, 0, 1);
        go(BBIO_OP_WORD_IN, 0, 0, 1, 0, 0, 42, 45, 0, 0);
        go(BBIO_OP_WORD_IN, 1, 1, 1, 0, 1, 50, 46, 0, 0);
        go(BBIO_OP_CHAR_IN, 1, 0, 0, 0, 1, 200, 212, 4, 0);
        go(BBIO_OP_CHAR_OUT, 0, 0, 0, 0, 1, 216, 226, 0, 1);
        go(BBIO_OP_CHAR_OUT, 0, 1, 1, 0, 0, 240, 230, 0, 1);
        conclude();
    end
endmodule : test_bbio_engine
